/* logic/txflp_top.sv */
// Purpose: transmit fifo, byte ordering reader, dma request control and loopback routing
// Assumes: dma data arrives with byte enables marking packet bytes; serializer byte pacing
// Notes: one clock, synchronous active-high reset
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
module txflp_top #(
  parameter int DEPTH = 8
) (
  // system
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // dma side
  output logic dma_req,
  input wire logic dma_gnt,
  input wire txflp_pkg::txflp_dma_t dma_in,
  output logic dma_ready,
  // serializer side
  input wire logic ser_take,
  output txflp_pkg::txflp_byte_t ser_out,
  // endec and network
  output logic endec_loop_request,
  output logic endec_tx_en,
  input wire logic collision_pair_inputs,
  input wire logic rx_from_net_valid,
  // receive path results
  input wire logic src_addr_match,
  input wire logic rx_accept,
  input wire logic rx_reject,
  input wire logic rx_crc_err,
  input wire logic rx_align_err,
  input wire logic rx_missed,
  output logic rx_store_en,
  output logic rx_from_mac_loop
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH * 4) + 1;

  // fifo storage: four byte lanes, DEPTH entries
  logic [7:0] mem [DEPTH][4];
  logic [3:0] vld [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [1:0] lane_reg, lane_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic half_reg, half_next;
  logic [CW-1:0] burst_reg, burst_next;
  logic run_reg, run_next;
  logic last_in_reg, last_in_next;
  logic [15:0] cmd_reg, cmd_next, dcr_reg, dcr_next, data_config_second_reg, data_config_second_next;
  logic [15:0] rcr_reg, rcr_next, tcr_reg, tcr_next;
  logic [15:0] checksum_error_tally_reg, checksum_error_tally_next, alignment_error_tally_reg, alignment_error_tally_next, mpt_reg, mpt_next;
  logic [31:0] dat_reg, dat_next;
  logic ack_reg, ack_next;
  txflp_pkg::txflp_byte_t out_reg, out_next;
  logic req_reg, req_next;
  logic loopreq_reg, loopreq_next, txen_reg, txen_next, store_reg, store_next;
  logic macl_reg, macl_next;
  typedef enum {ST_IDLE, ST_SEND, ST_WAIT_RX} txflp_state_t;
  txflp_state_t st_reg, st_next;

  logic [CW-1:0] thr_bytes;
  logic wide, big, blk;
  txflp_pkg::txflp_lb_t lb;
  logic wr_fire, rd_fire, pkt_end, hi;
  logic [2:0] nbytes;
  logic [1:0] lane_phys;
  logic [3:0] be_eff;
  logic [CW-1:0] space;

  function automatic logic [2:0] popc(input logic [3:0] b);
    popc = 3'(b[0]) + 3'(b[1]) + 3'(b[2]) + 3'(b[3]);
  endfunction

  always_comb begin
    wide = dcr_reg[txflp_pkg::DCR_DW_BIT];
    blk = dcr_reg[txflp_pkg::DCR_BMS_BIT];
    big = dcr_reg[txflp_pkg::DCR_BIGEND_BIT];
    // threshold of 1 to 4 words; stays below fifo size so the reader can start
    thr_bytes = CW'((dcr_reg[txflp_pkg::DCR_TFT_LSB +: 2] + 1) * (wide ? 4 : 2));
    lb = txflp_pkg::txflp_lb_t'(rcr_reg[txflp_pkg::RCR_LB_LSB +: 2]);
    // 16-bit mode writes one half per transfer
    // a packet may start in the upper half of an entry
    hi = half_reg || dma_in.be[1:0] == 2'b00;
    be_eff = wide ? dma_in.be : (hi ? {dma_in.be[3:2], 2'b00} : {2'b00, dma_in.be[1:0]});
    nbytes = popc(be_eff); // arbitrary alignment via byte enables
    space = CW'(DEPTH * 4) - cnt_reg;
    dma_ready = run_reg && burst_reg != '0 && space >= CW'(wide ? 4 : 2);
    wr_fire = dma_in.valid && dma_ready;
    // one read pointer plus a lane index: lane order reversed in big endian
    lane_phys = big ? ~lane_reg : lane_reg;
    // start only once count exceeds threshold, or rest of packet is
    // filler lanes are never read, only skipped
    rd_fire = (cnt_reg > thr_bytes || last_in_reg) && cnt_reg != '0 && ser_take
      && !out_reg.valid && vld[rp_reg][lane_phys];
    pkt_end = rd_fire && last_in_reg && cnt_reg == CW'(1);
  end

  // fifo write and read pointers
  always_comb begin
    wp_next = wp_reg;
    rp_next = rp_reg;
    lane_next = lane_reg;
    half_next = half_reg;
    cnt_next = cnt_reg;
    last_in_next = last_in_reg;
    burst_next = burst_reg;
    req_next = req_reg;
    out_next = '0;
    if (wr_fire) begin
      cnt_next = cnt_next + CW'(nbytes);
      burst_next = (burst_reg > CW'(wide ? 4 : 2)) ? burst_reg - CW'(wide ? 4 : 2) : '0;
      if (dma_in.last) last_in_next = 1'b1;
      if (wide || hi || dma_in.last) begin
        wp_next = AW'(wp_reg + 1'b1);
        half_next = 1'b0;
      end else begin
        half_next = 1'b1;
      end
    end
    // skip filler lanes; each read takes next valid byte
    if (rd_fire) begin
      out_next.valid = 1'b1;
      out_next.data = mem[rp_reg][lane_phys];
      out_next.last = pkt_end;
      cnt_next = cnt_next - CW'(1);
    end
    if (cnt_reg != '0 && (!vld[rp_reg][lane_phys] || rd_fire)) begin
      lane_next = lane_reg + 2'd1;
      if (lane_reg == 2'd3) rp_next = AW'(rp_reg + 1'b1);
    end
    // refill request while at or below threshold
    if (run_reg && !last_in_reg && burst_reg == '0 && !req_reg && cnt_reg <= thr_bytes)
      req_next = 1'b1;
    if (req_reg && dma_gnt) begin
      req_next = 1'b0;
      // block: threshold bytes; empty/fill: all free room
      burst_next = blk ? thr_bytes : space;
    end
    // clean fifo for next packet
    if (pkt_end || !run_reg) begin
      wp_next = '0;
      rp_next = '0;
      lane_next = '0;
      half_next = 1'b0;
      cnt_next = '0;
      last_in_next = 1'b0;
      burst_next = '0;
      req_next = 1'b0;
    end
  end

  // packet sequence and loopback routing
  always_comb begin
    st_next = st_reg;
    run_next = run_reg;
    tcr_next = tcr_reg;
    loopreq_next = lb == txflp_pkg::LB_ENDEC;
    // mac loop keeps endec pins quiet
    txen_next = run_reg && lb != txflp_pkg::LB_MAC && lb != txflp_pkg::LB_ENDEC;
    macl_next = lb == txflp_pkg::LB_MAC && out_reg.valid;
    // echo stored only in loopback, otherwise just monitored
    store_next = lb != txflp_pkg::LB_NONE && cmd_reg[txflp_pkg::CMD_RECEIVER_ENABLE_BIT]
      && (rx_from_net_valid || lb == txflp_pkg::LB_MAC);
    case (st_reg)
      ST_IDLE: begin
        if (cmd_reg[txflp_pkg::CMD_TX_BIT]) begin
          st_next = ST_SEND;
          run_next = 1'b1;
          tcr_next = '0;
        end
      end
      ST_SEND: begin
        if (pkt_end) begin
          run_next = 1'b0;
          tcr_next[txflp_pkg::TCR_PTX_BIT] = 1'b1;
          st_next = lb == txflp_pkg::LB_NONE ? ST_IDLE : ST_WAIT_RX;
        end
      end
      ST_WAIT_RX: begin
        if (rx_accept || rx_reject) st_next = ST_IDLE;
      end
      default: st_next = ST_IDLE;
    endcase
    // collisions do not reach loopback logic
    if (collision_pair_inputs && lb == txflp_pkg::LB_NONE && st_reg == ST_SEND)
      tcr_next[txflp_pkg::TCR_PTX_BIT] = 1'b0;
    if (st_reg != ST_IDLE && rx_from_net_valid && !src_addr_match)
      tcr_next[txflp_pkg::TCR_PMB_BIT] = 1'b1;
  end

  // register file: 16 bits each in the low half
  always_comb begin
    cmd_next = cmd_reg;
    dcr_next = dcr_reg;
    data_config_second_next = data_config_second_reg;
    rcr_next = rcr_reg;
    checksum_error_tally_next = checksum_error_tally_reg + 16'(rx_crc_err);
    alignment_error_tally_next = alignment_error_tally_reg + 16'(rx_align_err);
    mpt_next = mpt_reg + 16'(rx_missed);
    dat_next = dat_reg;
    ack_next = 1'b0;
    if (st_reg == ST_IDLE && cmd_reg[txflp_pkg::CMD_TX_BIT]) cmd_next[txflp_pkg::CMD_TX_BIT] = 1'b0;
    if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      ack_next = 1'b1;
      dat_next = '0;
      if (wb_adr_i == txflp_pkg::OFF_CMD) begin
        dat_next[15:0] = cmd_reg;
        if (wb_we_i && wb_sel_i[0]) cmd_next[7:0] = wb_dat_i[7:0];
        if (wb_we_i && wb_sel_i[1]) cmd_next[15:8] = wb_dat_i[15:8];
      end else if (wb_adr_i == txflp_pkg::OFF_DCR) begin
        dat_next[15:0] = dcr_reg;
        if (wb_we_i && wb_sel_i[0]) dcr_next[7:0] = wb_dat_i[7:0];
        if (wb_we_i && wb_sel_i[1]) dcr_next[15:8] = wb_dat_i[15:8];
      end else if (wb_adr_i == txflp_pkg::OFF_DATA_CONFIG_SECOND) begin
        dat_next[15:0] = data_config_second_reg;
        if (wb_we_i && wb_sel_i[0]) data_config_second_next[7:0] = wb_dat_i[7:0];
        if (wb_we_i && wb_sel_i[1]) data_config_second_next[15:8] = wb_dat_i[15:8];
      end else if (wb_adr_i == txflp_pkg::OFF_RCR) begin
        dat_next[15:0] = rcr_reg;
        if (wb_we_i && wb_sel_i[0]) rcr_next[7:0] = wb_dat_i[7:0];
        if (wb_we_i && wb_sel_i[1]) rcr_next[15:8] = wb_dat_i[15:8];
      end else if (wb_adr_i == txflp_pkg::OFF_TCR) begin
        dat_next[15:0] = tcr_reg;
      end else if (wb_adr_i == txflp_pkg::OFF_CHECKSUM_ERROR_TALLY) begin
        dat_next[15:0] = checksum_error_tally_reg;
        if (wb_we_i) checksum_error_tally_next = '0;
      end else if (wb_adr_i == txflp_pkg::OFF_ALIGNMENT_ERROR_TALLY) begin
        dat_next[15:0] = alignment_error_tally_reg;
        if (wb_we_i) alignment_error_tally_next = '0;
      end else if (wb_adr_i == txflp_pkg::OFF_MPT) begin
        dat_next[15:0] = mpt_reg;
        if (wb_we_i) mpt_next = '0;
      end else if (wb_adr_i == txflp_pkg::OFF_FSTAT) begin
        dat_next[15:0] = 16'({st_reg == ST_IDLE ? 1'b0 : 1'b1, cnt_reg});
      end
    end
  end

  // fifo array write: lanes filled only where byte enables mark packet bytes
  always_ff @(posedge clk) begin
    if (rst || pkt_end || !run_reg) begin
      for (int i = 0; i < DEPTH; i++) vld[i] <= 4'h0;
    end else begin
      if (wr_fire) vld[wp_reg] <= vld[wp_reg] | be_eff;
      if (rd_fire) vld[rp_reg][lane_phys] <= 1'b0;
    end
    if (wr_fire) begin
      for (int l = 0; l < 4; l++) if (be_eff[l]) mem[wp_reg][l] <= dma_in.data[8*l +: 8];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      lane_reg <= '0;
      half_reg <= 1'b0;
      cnt_reg <= '0;
      last_in_reg <= 1'b0;
      burst_reg <= '0;
      req_reg <= 1'b0;
      out_reg <= '0;
      st_reg <= ST_IDLE;
      run_reg <= 1'b0;
      tcr_reg <= '0;
      loopreq_reg <= 1'b0;
      txen_reg <= 1'b0;
      store_reg <= 1'b0;
      macl_reg <= 1'b0;
      cmd_reg <= '0;
      dcr_reg <= txflp_pkg::DCR_RST;
      data_config_second_reg <= '0;
      rcr_reg <= txflp_pkg::RCR_RST;
      checksum_error_tally_reg <= '0;
      alignment_error_tally_reg <= '0;
      mpt_reg <= '0;
      dat_reg <= '0;
      ack_reg <= 1'b0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      lane_reg <= lane_next;
      half_reg <= half_next;
      cnt_reg <= cnt_next;
      last_in_reg <= last_in_next;
      burst_reg <= burst_next;
      req_reg <= req_next;
      out_reg <= out_next;
      st_reg <= st_next;
      run_reg <= run_next;
      tcr_reg <= tcr_next;
      loopreq_reg <= loopreq_next;
      txen_reg <= txen_next;
      store_reg <= store_next;
      macl_reg <= macl_next;
      cmd_reg <= cmd_next;
      dcr_reg <= dcr_next;
      data_config_second_reg <= data_config_second_next;
      rcr_reg <= rcr_next;
      checksum_error_tally_reg <= checksum_error_tally_next;
      alignment_error_tally_reg <= alignment_error_tally_next;
      mpt_reg <= mpt_next;
      dat_reg <= dat_next;
      ack_reg <= ack_next;
    end
  end

  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;
  assign dma_req = req_reg;
  assign ser_out = out_reg;
  assign endec_loop_request = loopreq_reg;
  assign endec_tx_en = txen_reg;
  assign rx_store_en = store_reg;
  assign rx_from_mac_loop = macl_reg;
endmodule // txflp_top

/* logic/txflp_pkg.sv */
// Purpose: shared constants and carriers for the transmit fifo and loopback path
// Assumes: wishbone classic slave, 16-bit registers in the low half of each word
// Notes: offsets are byte addresses
package txflp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_DCR = 8'h04;
  localparam logic [7:0] OFF_DATA_CONFIG_SECOND = 8'h08;
  localparam logic [7:0] OFF_RCR = 8'h0c;
  localparam logic [7:0] OFF_TCR = 8'h10;
  localparam logic [7:0] OFF_CHECKSUM_ERROR_TALLY = 8'h14;
  localparam logic [7:0] OFF_ALIGNMENT_ERROR_TALLY = 8'h18;
  localparam logic [7:0] OFF_MPT = 8'h1c;
  localparam logic [7:0] OFF_FSTAT = 8'h20;
  // command bits
  localparam int CMD_TX_BIT = 1;
  localparam int CMD_RECEIVER_ENABLE_BIT = 3;
  // data_config_main fields
  localparam int DCR_DW_BIT = 5;
  localparam int DCR_BMS_BIT = 4;
  localparam int DCR_TFT_LSB = 0;
  localparam int DCR_BIGEND_BIT = 6;
  // data_config_second field
  localparam int DATA_CONFIG_SECOND_TRANSCEIVER_WRAP_ENABLE_BIT = 0;
  // receive control loopback field
  localparam int RCR_LB_LSB = 9;
  // transmit status bits
  localparam int TCR_PTX_BIT = 0;
  localparam int TCR_PMB_BIT = 3;
  // reset values
  localparam logic [15:0] DCR_RST = 16'h0000;
  localparam logic [15:0] RCR_RST = 16'h0000;
  localparam int FIFO_BYTES = 32;
  typedef enum logic [1:0] {LB_NONE, LB_MAC, LB_ENDEC, LB_XCVR} txflp_lb_t;
  typedef struct packed {
    logic valid;
    logic [31:0] data;
    logic [3:0] be;
    logic last;
  } txflp_dma_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } txflp_byte_t;
endpackage

/* test/txflp_top_chk.sv */
// Purpose: port checker for the transmit fifo and loopback path
// Assumes: loopback field followed from host writes to the receive control register
// Notes: bound to every txflp_top
`timescale 1ns/1ps
module txflp_top_chk (
  // system
  input wire logic clk,
  input wire logic rst,
  // host bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // dma and stream
  input wire logic dma_req,
  input wire logic dma_gnt,
  input wire txflp_pkg::txflp_byte_t ser_out,
  // loopback
  input wire logic endec_loop_request,
  input wire logic endec_tx_en,
  input wire logic rx_store_en
);
  logic [1:0] lb_reg;
  logic [1:0] lb_next;
  always_comb begin
    lb_next = lb_reg;
    if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[1] &&
        wb_adr_i == txflp_pkg::OFF_RCR) begin
      lb_next = wb_dat_i[10:9];
    end
  end
  // one cycle behind the design's update; the stability windows absorb it
  always_ff @(posedge clk) begin
    if (rst) begin
      lb_reg <= 2'h0;
    end else begin
      lb_reg <= lb_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_req_hold: assert property (dma_req && !dma_gnt |=> dma_req)
    else $error("request dropped before grant");
  a_byte_gap: assert property (ser_out.valid |=> !ser_out.valid) else $error("bytes too close");
  a_endec_loop: assert property ($stable(lb_reg) [*3] |-> endec_loop_request == (lb_reg == 2'h2))
    else $error("loop request does not follow mode");
  a_mac_quiet: assert property ((lb_reg == 2'h1) [*2] |-> !endec_tx_en)
    else $error("transmit enable in mac loopback");
  a_echo_only: assert property ((lb_reg == 2'h0) [*2] |-> !rx_store_en)
    else $error("echo stored outside loopback");
  a_rst_quiet: assert property (disable iff (1'b0)
    rst |=> !wb_ack_o && !dma_req && !ser_out.valid && !endec_loop_request)
    else $error("output active after reset");
endmodule // txflp_top_chk
bind txflp_top txflp_top_chk u_chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .dma_req(dma_req), .dma_gnt(dma_gnt),
  .ser_out(ser_out), .endec_loop_request(endec_loop_request), .endec_tx_en(endec_tx_en),
  .rx_store_en(rx_store_en));

/* test/txflp_mem_model.sv */
// Purpose: system memory behind the dma grant, serving one packet at a time
// Assumes: grant rises lat+1 cycles after request and falls the cycle after request falls
// Notes: narrow mode is modelled for little endian only
`timescale 1ns/1ps
module txflp_mem_model (
  // system
  input wire logic clk,
  input wire logic rst,
  // packet setup
  input wire logic go,
  input wire logic wide,
  input wire logic big,
  input wire logic [1:0] off,
  input wire logic [7:0] len,
  input wire logic [1:0] lat,
  // dma
  input wire logic dma_req,
  input wire logic dma_ready,
  output logic dma_gnt,
  output txflp_pkg::txflp_dma_t dma_in
);
  logic [7:0] pos, a, nxt;
  logic [1:0] wc;
  logic act;
  always_comb begin
    dma_in = '0;
    dma_in.data = 32'heeeeeeee;
    nxt = wide ? {pos[7:2], 2'h0} + 8'h04 : {pos[7:1], 1'h0} + 8'h02;
    for (int i = 0; i < 4; i++) begin
      a = {pos[7:2], 2'h0} + 8'(big ? 3 - i : i);
      if (wide || (i >> 1) == int'(pos[1])) begin
        dma_in.be[i] = a >= 8'(off) && a < 8'(off) + len;
        // filler lanes keep ee so a leak shows up as a wrong byte
        dma_in.data[8*i +: 8] = dma_in.be[i] ? a - 8'(off) + 8'h01 : 8'hee;
      end
    end
    dma_in.last = nxt >= 8'(off) + len;
    // words stay offered; the design's ready bounds each burst
    dma_in.valid = act;
  end
  always_ff @(posedge clk) begin
    if (rst || go) begin
      pos <= 8'(off);
      act <= go;
    end else if (dma_in.valid && dma_ready) begin
      pos <= nxt;
      act <= !dma_in.last;
    end
    if (rst || !dma_req) begin
      wc <= 2'h0;
      dma_gnt <= 1'b0;
    end else if (wc == lat) begin
      dma_gnt <= 1'b1;
    end else begin
      wc <= wc + 2'h1;
    end
  end
endmodule // txflp_mem_model

/* test/test_txflp_top.sv */
// Purpose: self-checking bench for the transmit fifo and loopback path
// Assumes: bench samples at the falling edge, drives at the rising edge
// Notes: the memory model supplies numbered packet bytes
`timescale 1ns/1ps
module test_txflp_top;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, take = 1, go = 0, wide = 0, big = 0;
  logic col = 0, rxv = 0, mt = 1, ok = 0, rej = 0, crc = 0, aln = 0, mis = 0;
  logic [7:0] adr = '0, len = '0;
  logic [1:0] off = '0, lat = '0;
  logic [31:0] dat = '0, q, rd;
  logic req, gnt, rdy, ack, lreq, txen, pg, bm, lstin, txs, lrs, sto, mlp, sts, mls;
  txflp_pkg::txflp_dma_t din;
  txflp_pkg::txflp_byte_t so;
  int error_cnt = 0, samples_checked = 0, thr, acc, epi;
  logic [8:0] got[$];
  txflp_top u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack),
    .dma_req(req), .dma_gnt(gnt), .dma_in(din), .dma_ready(rdy), .ser_take(take),
    .ser_out(so), .endec_loop_request(lreq), .endec_tx_en(txen),
    .collision_pair_inputs(col), .rx_from_net_valid(rxv), .src_addr_match(mt),
    .rx_accept(ok), .rx_reject(rej), .rx_crc_err(crc), .rx_align_err(aln),
    .rx_missed(mis), .rx_store_en(sto), .rx_from_mac_loop(mlp));
  txflp_mem_model u_mem (.clk(clk), .rst(rst), .go(go), .wide(wide), .big(big), .off(off),
    .len(len), .lat(lat), .dma_req(req), .dma_ready(rdy), .dma_gnt(gnt), .dma_in(din));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= {16'h0, d};
    n = 0;
    @(negedge clk);
    while (ack !== 1'b1) begin
      n++;
      if (n > 20) begin
        error_cnt++;
        test_done;
      end
      @(negedge clk);
    end
    rd = q;
    @(posedge clk);
    cyc <= 0;
    stb <= 0;
  endtask
  always @(negedge clk) begin
    if (din.valid && rdy) begin
      acc += $countones(din.be);
      epi++;
      lstin |= din.last;
    end
    // a burst ends before the next grant; the one with the last word may be short
    if (!pg && gnt) begin
      if (bm && !lstin && epi != 0) chk("burst", thr, epi * (wide ? 4 : 2));
      epi = 0;
    end
    pg = gnt;
    if (so.valid) begin
      if (got.size() == 0) chk("start", 1, acc > thr || lstin);
      got.push_back({so.last, so.data});
    end
    txs |= txen;
    lrs |= lreq;
    sts |= sto;
    mls |= mlp;
  end
  task automatic regs;
    wb(0, txflp_pkg::OFF_DCR, 16'h0);
    chk("dcr_reset", {16'h0, txflp_pkg::DCR_RST}, rd);
    wb(1, txflp_pkg::OFF_DCR, 16'hffff);
    wb(0, txflp_pkg::OFF_DCR, 16'h0);
    chk("dcr_upper", 0, rd[31:16]);
    wb(0, 8'h3c, 16'h0);
    chk("unmapped", 0, rd);
    for (int t = 0; t < 3; t++) begin
      wb(1, txflp_pkg::OFF_CHECKSUM_ERROR_TALLY + 8'(4 * t), 16'h0);
      crc <= t == 0;
      aln <= t == 1;
      mis <= t == 2;
      repeat (t + 2) @(posedge clk);
      {crc, aln, mis} <= 3'h0;
      wb(0, txflp_pkg::OFF_CHECKSUM_ERROR_TALLY + 8'(4 * t), 16'h0);
      chk("tally", t + 2, rd);
    end
    $display("register test done");
  endtask
  task automatic pkt(input logic w, b, input logic [1:0] o, input logic [7:0] l,
      input logic [1:0] c, input logic bs, input logic [1:0] lb, input logic m, s);
    int n;
    wb(1, txflp_pkg::OFF_RCR, {5'h0, lb, 9'h0});
    wb(1, txflp_pkg::OFF_DATA_CONFIG_SECOND, {15'h0, lb == 2'h3});
    wb(1, txflp_pkg::OFF_DCR, {9'h0, b, w, bs, 2'h0, c});
    thr = (c + 1) * (w ? 4 : 2);
    bm = bs;
    {acc, epi, lstin, txs, lrs, sts, mls} = '0;
    got.delete();
    @(posedge clk);
    {wide, big, off, len, mt} <= {w, b, o, l, m};
    {col, rxv, take, go} <= {lb != 2'h0, 1'b1, !s, 1'b1};
    lat <= lat + 2'h1;
    @(posedge clk);
    go <= 0;
    wb(1, txflp_pkg::OFF_CMD, 16'h000a);
    if (s) begin
      repeat (80) @(negedge clk);
      chk("fill", bs ? 2 * thr : 32, acc);
      chk("req", 0, req);
      @(posedge clk);
      take <= 1;
    end
    n = 0;
    while (got.size() < l) begin
      @(negedge clk);
      n++;
      if (n > 3000) begin
        error_cnt++;
        test_done;
      end
    end
    for (int k = 0; k < l; k++) chk("byte", {k == l - 1, 8'(k + 1)}, got[k]);
    chk("tx_en", lb == 0 || lb == 3, txs);
    chk("loop_req", lb == 2, lrs);
    chk("store", lb != 0, sts);
    chk("mac_loop", lb == 1, mls);
    @(posedge clk);
    {ok, rej} <= {m, !m};
    @(posedge clk);
    {ok, rej, rxv} <= 3'h0;
    repeat (4) @(posedge clk);
    wb(0, txflp_pkg::OFF_TCR, 16'h0);
    chk("monitored_bad", !m, rd[3]);
    $display("packet test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    regs;
    pkt(1, 0, 0, 40, 1, 1, 0, 1, 1);
    pkt(1, 0, 0, 40, 3, 0, 0, 1, 1);
    pkt(1, 0, 1, 13, 0, 1, 1, 1, 0);
    pkt(0, 0, 3, 10, 1, 0, 2, 1, 0);
    pkt(0, 0, 1, 7, 0, 1, 3, 1, 0);
    pkt(1, 1, 2, 9, 2, 1, 0, 0, 0);
    test_done;
  end
endmodule // test_txflp_top
